// *** logic/trap_unit_consts.svh ***
// constants for the breakpoint trap unit
// Notes on behaviour
// - registers reached indirectly: index written at CEh, data at CFh
// - control write: rom, mem addr, mem data, write, read, io, single step
// - control read: enables bits 0-4, bit 5 write trap, bit 6 read trap
// - index one is the data mask; one bit includes that data bit
// - index two: rom address low, else memory trap address
// - index three: rom address high, else memory data compare value
// - writing zero to control disables every trap and single step
// - control 01h traps on rom fetch at address {idx3, idx2}
// - 12h, 0Ah, 1Ah trap on read, write or either at index two address
// - 14h, 0Ch, 1Ch trap on read, write or either with masked data match
// - 16h, 0Eh, 1Eh trap when address and masked data both match
// - control 80h single steps, trapping after every executed instruction
`ifndef TRAP_UNIT_CONSTS_SVH
`define TRAP_UNIT_CONSTS_SVH
`define ADDR_INDEX_SELECT  8'hCE
`define ADDR_DATA_WINDOW   8'hCF
`define ADDR_IRQ_STATUS    8'hD0
`define ADDR_IRQ_ENABLE    8'hD1
`define ADDR_IRQ_CLEAR     8'hD2
`define IDX_CONTROL        2'h0
`define IDX_MASK           2'h1
`define IDX_LOW            2'h2
`define IDX_HIGH           2'h3
`define CTL_ROM            0
`define CTL_MADDR          1
`define CTL_MDATA          2
`define CTL_WRITE          3
`define CTL_READ           4
`define CTL_IO             5
`define CTL_WR_CAUSE       5
`define CTL_RD_CAUSE       6
`define CTL_STEP           7
`define RESET_CONTROL      8'h00
`define RESET_MASK         8'hFF
`define RESET_BYTE         8'h00
`define IRQ_ROM            0
`define IRQ_MEM            1
`define IRQ_STEP           2
`define IRQ_BITS           3
`endif

// *** logic/trap_unit_pkg.sv ***
// types for the breakpoint trap unit
`default_nettype none
package trap_unit_pkg;
   typedef enum logic [1:0] {
      KIND_NONE = 2'h0,
      KIND_ROM  = 2'h1,
      KIND_MEM  = 2'h2,
      KIND_STEP = 2'h3
   } trap_kind_type;
endpackage
`default_nettype wire

// *** logic/trap_regs.sv ***
// three-entry debug register store (indexes one to three) with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "trap_unit_consts.svh"
module trap_regs
(
   input  wire logic       clk,       // system clock
   input  wire logic       rst,       // async reset, high
   input  wire logic       wr_en,     // write strobe
   input  wire logic [1:0] wr_idx,    // written entry
   input  wire logic [7:0] wr_data,   // written value
   input  wire logic [1:0] rd_idx,    // read entry
   output logic      [7:0] rd_data,   // registered read value
   output logic      [7:0] mask,      // entry one
   output logic      [7:0] low,       // entry two
   output logic      [7:0] high       // entry three
);
   logic [7:0] mem_reg [1:3];

   // entries one to three; entry zero lives in the top module
   genvar g;
   generate
      for (g = 1; g < 4; g++)
      begin : g_ent
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               mem_reg[g] <= (g == 1) ? `RESET_MASK : `RESET_BYTE;
            else if (wr_en && wr_idx == 2'(g))
               mem_reg[g] <= wr_data;
         end
      end
   endgenerate

   // read port registered so the top sees a flop output
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rd_data <= 8'h00;
      else
         rd_data <= (rd_idx == 2'h0) ? 8'h00 : mem_reg[rd_idx];
   end

   assign mask = mem_reg[1];
   assign low  = mem_reg[2];
   assign high = mem_reg[3];
endmodule // trap_regs
`default_nettype wire

// *** logic/breakpoint_trap_unit.sv ***
// breakpoint trap unit: watches cpu fetches and memory cycles, raises debug traps
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "trap_unit_consts.svh"
module breakpoint_trap_unit
   import trap_unit_pkg::*;
(
   input  wire logic        CLK_SYS,     // 100 MHz system clock
   input  wire logic        RST,         // async reset, high
   input  wire logic [7:0]  ADDR,        // register address
   input  wire logic [7:0]  WDATA,       // register write data
   input  wire logic        WR,          // write strobe
   input  wire logic        RD,          // read strobe
   output logic      [7:0]  RDATA,       // read data, cycle after RD
   input  wire logic        FETCH,       // cpu opcode fetch strobe
   input  wire logic [15:0] FETCH_ADDR,  // rom fetch address
   input  wire logic        MEM_RD,      // cpu memory read strobe
   input  wire logic        MEM_WR,      // cpu memory write strobe
   input  wire logic [7:0]  MEM_ADDR,    // memory cycle address
   input  wire logic [7:0]  MEM_DATA,    // memory cycle data
   input  wire logic        INSTR_DONE,  // cpu finished an instruction
   output logic             TRAP,        // one-cycle debug trap pulse
   output logic             IRQ          // level interrupt
);
   logic [7:0]    ctl_reg;
   logic [1:0]    index_reg;
   logic          wr_cause_reg;
   logic          rd_cause_reg;
   logic [`IRQ_BITS-1:0] irq_stat_reg;
   logic [`IRQ_BITS-1:0] irq_en_reg;
   logic [7:0]    rdata_next;
   logic          rd_q_reg;
   logic          rd_win_reg;
   logic [7:0]    rd_direct_reg;
   logic [7:0]    win_data;
   logic [7:0]    mask;
   logic [7:0]    low;
   logic [7:0]    high;
   logic          win_wr;
   logic          ctl_wr;
   logic          rom_hit;
   logic          mem_hit;
   logic          step_hit;
   trap_kind_type kind;

   // masked data compare, shared by every data trap mode
   function automatic logic data_match(input logic [7:0] d, input logic [7:0] v,
                                       input logic [7:0] m);
      data_match = ((d ^ v) & m) == 8'h00;
   endfunction

   // index register: software selects the debug register first
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         index_reg <= `IDX_CONTROL;
      else if (WR && ADDR == `ADDR_INDEX_SELECT)
         index_reg <= WDATA[1:0];
   end

   assign win_wr = WR && ADDR == `ADDR_DATA_WINDOW;
   assign ctl_wr = win_wr && index_reg == `IDX_CONTROL;

   // entries one to three in the small store
   trap_regs u_regs
   (
      .clk     (CLK_SYS),
      .rst     (RST),
      .wr_en   (win_wr),
      .wr_idx  (index_reg),
      .wr_data (WDATA),
      .rd_idx  (index_reg),
      .rd_data (win_data),
      .mask    (mask),
      .low     (low),
      .high    (high)
   );

   // control enables; bit 6 is not stored, writing zero clears all
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         ctl_reg <= `RESET_CONTROL;
      else if (ctl_wr)
         ctl_reg <= WDATA & 8'hBF;
   end

   // rom fetch match on the full 16-bit address
   assign rom_hit = ctl_reg[`CTL_ROM] && FETCH
                    && FETCH_ADDR == {high, low};

   // memory match: address and/or masked data, on enabled cycle kinds
   always_comb
   begin
      logic cyc_ok;
      logic a_ok;
      logic d_ok;
      cyc_ok = (MEM_RD && ctl_reg[`CTL_READ]) || (MEM_WR && ctl_reg[`CTL_WRITE]);
      a_ok   = !ctl_reg[`CTL_MADDR] || MEM_ADDR == low;
      d_ok   = !ctl_reg[`CTL_MDATA] || data_match(MEM_DATA, high, mask);
      // rom mode takes indexes two and three, so memory modes stand aside
      mem_hit = !ctl_reg[`CTL_ROM] && cyc_ok
                && (ctl_reg[`CTL_MADDR] || ctl_reg[`CTL_MDATA]) && a_ok && d_ok;
   end

   assign step_hit = ctl_reg[`CTL_STEP] && INSTR_DONE;

   // classify the trap source for the status register
   always_comb
   begin
      if (rom_hit)
         kind = KIND_ROM;
      else if (mem_hit)
         kind = KIND_MEM;
      else if (step_hit)
         kind = KIND_STEP;
      else
         kind = KIND_NONE;
   end

   // trap pulse to the cpu, registered so the port is a flop
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         TRAP <= 1'b0;
      else
         TRAP <= kind != KIND_NONE;
   end

   // cause flags: a hit in the same cycle as a control write wins
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         wr_cause_reg <= 1'b0;
         rd_cause_reg <= 1'b0;
      end
      else
      begin
         if (mem_hit && MEM_WR)
            wr_cause_reg <= 1'b1;
         else if (ctl_wr)
            wr_cause_reg <= 1'b0;
         if (mem_hit && MEM_RD)
            rd_cause_reg <= 1'b1;
         else if (ctl_wr)
            rd_cause_reg <= 1'b0;
      end
   end

   // sticky interrupt status, set beats clear
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         irq_stat_reg <= '0;
      else
      begin
         for (int i = 0; i < `IRQ_BITS; i++)
         begin
            if (kind == trap_kind_type'(2'(i + 1)))
               irq_stat_reg[i] <= 1'b1;
            else if (WR && ADDR == `ADDR_IRQ_CLEAR && WDATA[i])
               irq_stat_reg[i] <= 1'b0;
         end
      end
   end

   // interrupt enable register
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         irq_en_reg <= '0;
      else if (WR && ADDR == `ADDR_IRQ_ENABLE)
         irq_en_reg <= WDATA[`IRQ_BITS-1:0];
   end

   // interrupt level from a flop, one cycle behind the status
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         IRQ <= 1'b0;
      else
         IRQ <= |(irq_stat_reg & irq_en_reg);
   end

   // direct read values, captured every cycle and shown after the strobe
   always_comb
   begin
      rdata_next = 8'h00;
      if (ADDR == `ADDR_INDEX_SELECT)
         rdata_next = {6'h00, index_reg};
      else if (ADDR == `ADDR_DATA_WINDOW && index_reg == `IDX_CONTROL)
         rdata_next = {ctl_reg[7], rd_cause_reg, wr_cause_reg, ctl_reg[4:0]};
      else if (ADDR == `ADDR_IRQ_STATUS)
         rdata_next = {5'h00, irq_stat_reg};
      else if (ADDR == `ADDR_IRQ_ENABLE)
         rdata_next = {5'h00, irq_en_reg};
   end

   // read pipeline; window entries one to three come from the store
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         rd_q_reg      <= 1'b0;
         rd_win_reg    <= 1'b0;
         rd_direct_reg <= 8'h00;
      end
      else
      begin
         rd_q_reg      <= RD;
         rd_win_reg    <= RD && ADDR == `ADDR_DATA_WINDOW && index_reg != `IDX_CONTROL;
         rd_direct_reg <= rdata_next;
      end
   end

   // read data stands only in the cycle after the strobe
   assign RDATA = !rd_q_reg ? 8'h00 : (rd_win_reg ? win_data : rd_direct_reg);

   // checks
   sequence s_wr_fetch;
      ctl_reg[`CTL_ROM] && FETCH && FETCH_ADDR == {high, low};
   endsequence

   a_rom_trap_pulse: assert property (@(posedge CLK_SYS) disable iff (RST)
      s_wr_fetch |=> TRAP)
      else $error("rom fetch match gave no trap");

   a_zero_ctl_quiet: assert property (@(posedge CLK_SYS) disable iff (RST)
      (ctl_wr && WDATA == 8'h00) |=> ##1 (ctl_reg == 8'h00 && !TRAP))
      else $error("trap after control cleared");

   a_cause_cleared: assert property (@(posedge CLK_SYS) disable iff (RST)
      (ctl_wr && !mem_hit) |=> (!wr_cause_reg && !rd_cause_reg))
      else $error("cause flag survived control write");

   a_write_cause: assert property (@(posedge CLK_SYS) disable iff (RST)
      (mem_hit && MEM_WR) |=> wr_cause_reg)
      else $error("write cause not latched");

   a_read_cause: assert property (@(posedge CLK_SYS) disable iff (RST)
      (mem_hit && MEM_RD) |=> rd_cause_reg)
      else $error("read cause not latched");

   a_step_trap: assert property (@(posedge CLK_SYS) disable iff (RST)
      (ctl_reg == 8'h80 && INSTR_DONE) |=> TRAP)
      else $error("single step gave no trap");

   a_no_cycle_kind: assert property (@(posedge CLK_SYS) disable iff (RST)
      (!ctl_reg[`CTL_READ] && !ctl_reg[`CTL_WRITE] && !rom_hit && !step_hit)
      |=> !TRAP)
      else $error("memory trap without cycle enable");

   a_mask_ignores: assert property (@(posedge CLK_SYS) disable iff (RST)
      (ctl_reg == 8'h14 && MEM_RD && ((MEM_DATA ^ high) & mask) == 8'h00) |=> TRAP)
      else $error("masked data match missed");

   a_addr_data_both: assert property (@(posedge CLK_SYS) disable iff (RST)
      (ctl_reg == 8'h1E && (MEM_RD || MEM_WR) && MEM_ADDR != low && !INSTR_DONE)
      |=> !TRAP)
      else $error("trap without address match");

   a_index_read: assert property (@(posedge CLK_SYS) disable iff (RST)
      (RD && ADDR == `ADDR_DATA_WINDOW && index_reg == `IDX_MASK) |=> RDATA == mask)
      else $error("window read returned wrong entry");
endmodule // breakpoint_trap_unit
`default_nettype wire

// *** sim/cpu_model.sv ***
// behavioural model of the embedded controller core that the trap unit watches
`timescale 1ns/1ns
`default_nettype none
module cpu_model
(
   input  wire logic        clk,         // system clock
   output var logic         fetch,       // opcode fetch strobe
   output var logic [15:0]  fetch_addr,  // fetch address
   output var logic         mem_rd,      // memory read strobe
   output var logic         mem_wr,      // memory write strobe
   output var logic [7:0]   mem_addr,    // memory address
   output var logic [7:0]   mem_data,    // memory data
   output var logic         instr_done   // instruction retired
);
   // strobes idle low; the buses start wherever the bench parks them
   initial
   begin
      fetch      = 1'b0;
      mem_rd     = 1'b0;
      mem_wr     = 1'b0;
      instr_done = 1'b0;
   end
   // park the buses on bench-chosen values; released lines later show the inverse
   // of their last value so stale data never matches
   task automatic park(input logic [15:0] fa, input logic [7:0] ma, input logic [7:0] md);
      fetch_addr <= fa;
      mem_addr   <= ma;
      mem_data   <= md;
   endtask
   // one opcode fetch, one cycle, then an idle cycle
   task automatic do_fetch(input logic [15:0] a);
      fetch_addr <= a;
      fetch      <= 1'b1;
      @(posedge clk);
      fetch      <= 1'b0;
      fetch_addr <= ~a;
      @(posedge clk);
   endtask
   // one memory cycle, read or write
   task automatic do_mem(input logic w, input logic [7:0] a, input logic [7:0] d);
      mem_wr   <= w;
      mem_rd   <= ~w;
      mem_addr <= a;
      mem_data <= d;
      @(posedge clk);
      mem_wr   <= 1'b0;
      mem_rd   <= 1'b0;
      mem_addr <= ~a;
      mem_data <= ~d;
      @(posedge clk);
   endtask
   // one retired instruction
   task automatic do_step();
      instr_done <= 1'b1;
      @(posedge clk);
      instr_done <= 1'b0;
      @(posedge clk);
   endtask
endmodule // cpu_model
`default_nettype wire

// *** sim/breakpoint_trap_unit_tb_top.sv ***
// self-checking bench for the breakpoint trap unit
`timescale 1ns/1ns
`default_nettype none
`include "trap_unit_consts.svh"
module breakpoint_trap_unit_tb_top;
   logic        CLK_SYS = 1'b0;
   logic        RST = 1'b1;
   logic [7:0]  ADDR;
   logic [7:0]  WDATA;
   logic        WR = 1'b0;
   logic        RD = 1'b0;
   logic [7:0]  RDATA;
   logic        FETCH, MEM_RD, MEM_WR, INSTR_DONE, TRAP, IRQ;
   logic [15:0] FETCH_ADDR;
   logic [7:0]  MEM_ADDR, MEM_DATA;
   logic [7:0]  rq[$];
   logic        tq[$];
   logic        rd_prev = 1'b0;
   logic        strobe_prev = 1'b0;
   logic [31:0] seed = 32'd84;
   logic [7:0]  modes[9] = '{8'h12, 8'h0A, 8'h1A, 8'h14, 8'h0C, 8'h1C, 8'h16, 8'h0E, 8'h1E};
   logic [7:0]  c, m, a, d, aa, dd, r;
   logic [2:0]  st = 3'h0;
   logic        wrc, rdc, e;
   int          errors = 0;
   int          comparisons = 0;
   always #5 CLK_SYS = ~CLK_SYS;
   breakpoint_trap_unit breakpoint_trap_unit_i (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .FETCH(FETCH), .FETCH_ADDR(FETCH_ADDR),
      .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR), .MEM_DATA(MEM_DATA),
      .INSTR_DONE(INSTR_DONE), .TRAP(TRAP), .IRQ(IRQ));
   cpu_model cpu_model_i (.clk(CLK_SYS), .fetch(FETCH), .fetch_addr(FETCH_ADDR), .mem_rd(MEM_RD),
      .mem_wr(MEM_WR), .mem_addr(MEM_ADDR), .mem_data(MEM_DATA), .instr_done(INSTR_DONE));
   // xorshift source, fixed start
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (rq.size() != 0 || tq.size() != 0)
         errors++;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // bus cycles: one strobe cycle then an idle cycle, so no strobe is driven twice per edge
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      ADDR  <= ad;
      WDATA <= dt;
      WR    <= 1'b1;
      @(posedge CLK_SYS);
      WR    <= 1'b0;
      @(posedge CLK_SYS);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
      rq.push_back(exp);
      ADDR <= ad;
      RD   <= 1'b1;
      @(posedge CLK_SYS);
      RD   <= 1'b0;
      @(posedge CLK_SYS);
   endtask
   task automatic wi(input logic [1:0] idx, input logic [7:0] dt);
      wr(`ADDR_INDEX_SELECT, {6'h00, idx});
      wr(`ADDR_DATA_WINDOW, dt);
   endtask
   task automatic ri(input logic [1:0] idx, input logic [7:0] exp);
      wr(`ADDR_INDEX_SELECT, {6'h00, idx});
      rd(`ADDR_DATA_WINDOW, exp);
   endtask
   // irq is launched on a rising edge, so it is looked at half a cycle later
   task automatic irq_chk(input logic exp);
      @(negedge CLK_SYS);
      check({7'h00, IRQ}, {7'h00, exp});
      @(posedge CLK_SYS);
   endtask
   // monitor on the falling edge: read data and trap stand one cycle after their cause
   always @(negedge CLK_SYS)
   begin
      if (rd_prev)
         check(RDATA, (rq.size() != 0) ? rq.pop_front() : 8'hEE);
      if (strobe_prev)
         check({7'h00, TRAP}, (tq.size() != 0) ? {7'h00, tq.pop_front()} : 8'hEE);
      else if (TRAP !== 1'b0)
         check({7'h00, TRAP}, 8'h00);
      rd_prev     = RD;
      strobe_prev = FETCH | MEM_RD | MEM_WR | INSTR_DONE;
   end
   // hang guard
   initial
   begin
      repeat (20000) @(posedge CLK_SYS);
      errors++;
      finish_test();
   end
   initial
   begin
      ADDR  <= rnd();
      WDATA <= rnd();
      cpu_model_i.park({rnd(), rnd()}, rnd(), rnd());
      repeat (12) @(posedge CLK_SYS);
      RST <= 1'b0;
      @(posedge CLK_SYS);
      ri(`IDX_CONTROL, 8'h00);
      ri(`IDX_MASK, 8'hFF);
      ri(`IDX_LOW, 8'h00);
      ri(`IDX_HIGH, 8'h00);
      rd(`ADDR_INDEX_SELECT, {6'h00, `IDX_HIGH});
      rd(8'h55, 8'h00);
      rd(`ADDR_IRQ_STATUS, 8'h00);
      // control write maps bits 5 and 6 away on read
      wi(`IDX_CONTROL, 8'hFF);
      ri(`IDX_CONTROL, 8'h9F);
      wi(`IDX_CONTROL, 8'h00);
      ri(`IDX_CONTROL, 8'h00);
      tq.push_back(1'b0);
      cpu_model_i.do_step();
      tq.push_back(1'b0);
      cpu_model_i.do_mem(1'b0, 8'h00, 8'h00);
      // rom fetch trap on {high, low}, near misses on each byte
      a = rnd();
      d = rnd();
      wi(`IDX_LOW, a);
      wi(`IDX_HIGH, d);
      wi(`IDX_CONTROL, 8'h01);
      tq.push_back(1'b1);
      cpu_model_i.do_fetch({d, a});
      tq.push_back(1'b0);
      cpu_model_i.do_fetch({d ^ 8'h01, a});
      tq.push_back(1'b0);
      cpu_model_i.do_fetch({d, a ^ 8'h80});
      st[0] = 1'b1;
      // with rom enabled, index two is a rom byte, so a memory read there must not trap
      wi(`IDX_CONTROL, 8'h13);
      tq.push_back(1'b0);
      cpu_model_i.do_mem(1'b0, a, 8'h00);
      tq.push_back(1'b1);
      cpu_model_i.do_fetch({d, a});
      // address enable without a cycle kind never traps
      wi(`IDX_CONTROL, 8'h02);
      tq.push_back(1'b0);
      cpu_model_i.do_mem(1'b0, a, 8'h00);
      // single step traps on every retired instruction, fetches ignored
      wi(`IDX_CONTROL, 8'h80);
      tq.push_back(1'b1);
      cpu_model_i.do_step();
      tq.push_back(1'b1);
      cpu_model_i.do_step();
      tq.push_back(1'b0);
      cpu_model_i.do_fetch({d, a});
      st[2] = 1'b1;
      // every memory mode with random mask, address and data
      foreach (modes[i])
      begin
         c = modes[i];
         m = rnd();
         a = rnd();
         d = rnd();
         wi(`IDX_MASK, m);
         wi(`IDX_LOW, a);
         wi(`IDX_HIGH, d);
         wi(`IDX_CONTROL, c);
         wrc = 1'b0;
         rdc = 1'b0;
         repeat (6)
         begin
            r  = rnd();
            aa = r[1] ? a : a ^ 8'h01;
            dd = r[2] ? d : d ^ rnd();
            e  = (r[0] ? c[3] : c[4]) && (!c[1] || aa == a)
                 && (!c[2] || ((dd ^ d) & m) == 8'h00);
            if (e && r[0])
               wrc = 1'b1;
            if (e && !r[0])
               rdc = 1'b1;
            if (e)
               st[1] = 1'b1;
            tq.push_back(e);
            cpu_model_i.do_mem(r[0], aa, dd);
         end
         ri(`IDX_CONTROL, {1'b0, rdc, wrc, c[4:0]});
      end
      // interrupt: masked, enabled, cleared
      rd(`ADDR_IRQ_STATUS, {5'h00, st});
      irq_chk(1'b0);
      wr(`ADDR_IRQ_ENABLE, 8'h07);
      irq_chk(st != 3'h0);
      rd(`ADDR_IRQ_ENABLE, 8'h07);
      wr(`ADDR_IRQ_CLEAR, {5'h00, st});
      irq_chk(1'b0);
      rd(`ADDR_IRQ_STATUS, 8'h00);
      // reset again mid-run: control, mask and enables fall back to reset values
      wr(`ADDR_IRQ_ENABLE, 8'h07);
      RST <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      RST <= 1'b0;
      @(posedge CLK_SYS);
      ri(`IDX_CONTROL, `RESET_CONTROL);
      ri(`IDX_MASK, `RESET_MASK);
      rd(`ADDR_IRQ_ENABLE, 8'h00);
      irq_chk(1'b0);
      repeat (3) @(posedge CLK_SYS);
      finish_test();
   end
endmodule // breakpoint_trap_unit_tb_top
`default_nettype wire
